// File: src/legacy_compat_ctrl.sv
`timescale 1ns/1ps
module legacy_compat_ctrl
    import legacy_compat_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic legacy_mode_fuse,
    input wire logic [15:0] data_addr,
    input wire logic io_instr,
    input wire logic [5:0] io_addr,
    output logic [15:0] io_data_addr,
    output logic io_sel,
    output logic ext_io_sel,
    output logic ram_sel,
    input wire logic [5:0] vec_index,
    output logic vec_enable,
    input wire logic rst_por,
    input wire logic rst_ext,
    input wire logic rst_bod,
    input wire logic rst_wdt,
    input wire logic rst_jtag,
    input wire logic [7:0] c_ddr,
    input wire logic [7:0] f_ddr,
    input wire logic [4:0] g_ddr,
    input wire logic [4:0] g_alt_sel,
    input wire logic [4:0] g_alt_oe,
    output logic [7:0] c_oe,
    output logic [7:0] f_oe,
    output logic [4:0] g_oe,
    output logic compat_mode,
    output logic mode_ready,
    output logic usart1_en,
    output logic usart_sync_en,
    output logic timer3_en,
    output logic ocr_c_en,
    output logic twi_en,
    output logic boot_en,
    output logic rx_fifo_en,
    output logic [11:0] baud_div,
    output logic [4:0] mcu_control_status_reg,
    output logic [2:0] wdt_timeout,
    output logic wdt_en,
    output logic [15:0] int_sense,
    output logic [2:0] xmem_release,
    output logic xmem_split,
    output logic [1:0] xmem_wait_lo,
    output logic [1:0] xmem_wait_hi,
    output logic [7:0] osccal
);
    typedef struct packed {
        logic [31:0] rdata;
        logic err;
        logic [6:0] feat;
        logic [11:0] baud;
        logic [4:0] rstf;
        logic [2:0] wd_to;
        logic wd_en;
        logic [2:0] wd_win;
        logic [15:0] sense;
        logic [7:0] xmem;
        logic [7:0] osc;
    } ctl_s;

    ctl_s st_ff;
    ctl_s nxt_st;
    logic compat;
    logic valid;
    logic wr;
    logic mapped;
    logic [31:0] rd_mux;
    logic [4:0] rst_set;
    logic ext_hit;
    logic io_hit;

    legacy_fuse_sampler u_fuse (
        .pclk(pclk),
        .presetn(presetn),
        .fuse_pin(legacy_mode_fuse),
        .mode(compat),
        .mode_valid(valid)
    );

    port_mode_gate u_ports (
        .compat(compat),
        .c_ddr(c_ddr),
        .f_ddr(f_ddr),
        .g_ddr(g_ddr),
        .g_alt_sel(g_alt_sel),
        .g_alt_oe(g_alt_oe),
        .c_oe(c_oe),
        .f_oe(f_oe),
        .g_oe(g_oe)
    );

    // Bus stalls until the mode is known, so no write is masked wrongly
    assign pready = valid;
    assign wr = psel & penable & pwrite & valid;
    assign rst_set = {rst_jtag, rst_wdt, rst_bod, rst_ext, rst_por};

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            A_MODE: rd_mux = {30'h0000_0000, valid, compat};
            A_FEAT: rd_mux = {25'h000_0000, st_ff.feat};
            A_STAT: rd_mux = {25'h000_0000, st_ff.feat};
            A_BAUD: rd_mux = {20'h0_0000, st_ff.baud};
            A_RSTF: rd_mux = {27'h000_0000, st_ff.rstf};
            A_WDT: rd_mux = {28'h000_0000, st_ff.wd_en, st_ff.wd_to};
            A_EXTI: rd_mux = {16'h0000, st_ff.sense};
            A_XMEM: rd_mux = {24'h00_0000, st_ff.xmem};
            A_OSC: rd_mux = {24'h00_0000, st_ff.osc};
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        if (psel) begin
            nxt_st.rdata = rd_mux;
            nxt_st.err = ~mapped;
        end
        if (st_ff.wd_win != 3'h0) begin
            nxt_st.wd_win = st_ff.wd_win - 3'h1;
        end
        if (wr && paddr == A_FEAT) begin
            // Legacy mode forbids the extra features
            nxt_st.feat = compat ? 7'h00 : pwdata[6:0];
        end
        if (wr && paddr == A_BAUD) begin
            nxt_st.baud = compat ? {4'h0, pwdata[7:0]} : pwdata[11:0];
        end
        nxt_st.rstf = st_ff.rstf;
        if (wr && paddr == A_RSTF) begin
            nxt_st.rstf = st_ff.rstf & pwdata[4:0];
        end
        nxt_st.rstf = nxt_st.rstf | rst_set;
        if (compat) begin
            nxt_st.rstf = nxt_st.rstf & RSTF_LEGACY;
        end
        if (wr && paddr == A_WDT) begin
            if (compat || st_ff.wd_win != 3'h0) begin
                nxt_st.wd_to = pwdata[2:0];
                nxt_st.wd_en = pwdata[WD_EN];
                nxt_st.wd_win = 3'h0;
            end else if (pwdata[WD_CHG] && pwdata[WD_EN]) begin
                nxt_st.wd_win = WDT_UNLOCK_CYC;
            end else begin
                nxt_st.wd_en = st_ff.wd_en | pwdata[WD_EN];
            end
        end
        if (wr && paddr == A_EXTI) begin
            nxt_st.sense = compat ? (pwdata[15:0] & EXTI_LEGACY_KEEP) : pwdata[15:0];
        end
        if (wr && paddr == A_XMEM) begin
            nxt_st.xmem = pwdata[7:0];
            if (compat) begin
                nxt_st.xmem[2:0] = 3'h0;
                nxt_st.xmem[XM_SPLIT] = 1'b0;
                nxt_st.xmem[XM_WHI +: 2] = pwdata[XM_WLO +: 2];
            end
        end
        if (wr && paddr == A_OSC && !compat) begin
            nxt_st.osc = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{rdata: 32'h0000_0000, err: 1'b0, feat: FEAT_RST, baud: BAUD_RST,
                rstf: RSTF_RST, wd_to: WD_TO_RST, wd_en: 1'b0, wd_win: 3'h0,
                sense: EXTI_RST, xmem: XMEM_RST, osc: OSC_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pslverr = st_ff.err;

    // Data space decode
    assign io_data_addr = io_instr ? (IO_BASE + {10'h000, io_addr}) : data_addr;
    assign ext_hit = data_addr >= EXT_LO && data_addr <= EXT_HI;
    assign io_hit = data_addr >= IO_BASE && data_addr <= IO_HI;
    assign io_sel = io_instr | io_hit;
    assign ext_io_sel = ~io_instr & ext_hit & ~compat;
    assign ram_sel = ~io_instr & (data_addr > IO_HI) & ~ext_io_sel;
    assign vec_enable = ~compat | (vec_index < VEC_LEGACY_CNT);

    assign compat_mode = compat;
    assign mode_ready = valid;
    assign usart1_en = st_ff.feat[F_USART1];
    assign usart_sync_en = st_ff.feat[F_SYNC];
    assign timer3_en = st_ff.feat[F_TMR3];
    assign ocr_c_en = st_ff.feat[F_OCRC];
    assign twi_en = st_ff.feat[F_TWI];
    assign boot_en = st_ff.feat[F_BOOT];
    assign rx_fifo_en = st_ff.feat[F_FIFO];
    assign baud_div = st_ff.baud;
    assign mcu_control_status_reg = st_ff.rstf;
    assign wdt_timeout = st_ff.wd_to;
    assign wdt_en = st_ff.wd_en;
    assign int_sense = st_ff.sense;
    assign xmem_release = st_ff.xmem[2:0];
    assign xmem_split = st_ff.xmem[XM_SPLIT];
    assign xmem_wait_lo = st_ff.xmem[XM_WLO +: 2];
    assign xmem_wait_hi = st_ff.xmem[XM_WHI +: 2];
    assign osccal = st_ff.osc;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ext_window: assert property (ext_io_sel |-> data_addr >= 16'h0060 && data_addr <= 16'h00ff)
        else $error("extended select outside its window");
    chk_short_form: assert property (io_instr |-> !ext_io_sel && io_sel)
        else $error("short form reached extended region");
    chk_io_addr_kept: assert property (io_instr |-> io_data_addr == 16'h0020 + {10'h000, io_addr})
        else $error("short form address moved");
    chk_ram_takeover: assert property (compat && !io_instr && ext_hit |-> ram_sel && !ext_io_sel)
        else $error("legacy region not mapped to ram");
    chk_vector_table: assert property (compat && vec_index >= VEC_LEGACY_CNT |-> !vec_enable)
        else $error("extended vector enabled in legacy mode");
    chk_features_off: assert property (compat && valid |=> !usart1_en && !usart_sync_en && !timer3_en && !ocr_c_en && !twi_en && !boot_en && !rx_fifo_en)
        else $error("extra feature on in legacy mode");
    chk_baud_low: assert property (compat && wr && paddr == A_BAUD |=> baud_div == {4'h0, $past(pwdata[7:0])})
        else $error("baud upper bits visible");
    chk_osc_frozen: assert property (compat && valid && $past(valid) |-> $stable(osccal))
        else $error("calibration changed in legacy mode");
    chk_xmem_uniform: assert property (compat && valid |=> xmem_release == 3'h0 && xmem_wait_hi == xmem_wait_lo)
        else $error("memory interface split in legacy mode");
    chk_rstf_mask: assert property (compat && valid |=> mcu_control_status_reg[4:2] == 3'h0)
        else $error("extra reset flag in legacy mode");
    chk_rstf_set_wins: assert property (rst_ext && wr && paddr == A_RSTF |=> mcu_control_status_reg[1])
        else $error("reset flag lost on clear");
    chk_wdt_direct: assert property (compat && wr && paddr == A_WDT |=> wdt_timeout == $past(pwdata[2:0]))
        else $error("legacy watchdog change refused");
    chk_wdt_locked: assert property (!compat && wr && paddr == A_WDT && st_ff.wd_win == 3'h0 |=> $stable(wdt_timeout))
        else $error("watchdog changed without unlock");
    chk_low_sense: assert property (compat && valid |=> int_sense[7:0] == 8'h00)
        else $error("edge sense on legacy low-level input");
    chk_port_dirs: assert property (compat |-> c_oe == 8'hff && f_oe == 8'h00 && g_oe == g_alt_oe)
        else $error("legacy port direction wrong");

    cov_legacy_mode: cover property ($rose(valid) && compat);
    cov_wdt_unlock: cover property (!compat && wr && paddr == A_WDT ##[1:4] wr && paddr == A_WDT);
    cov_flag_race: cover property (rst_por && wr && paddr == A_RSTF);
    cov_ext_access: cover property (ext_io_sel);
endmodule

// File: src/legacy_compat_pkg.sv
package legacy_compat_pkg;
    // Register byte offsets
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_FEAT = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_BAUD = 8'h0c;
    localparam logic [7:0] A_RSTF = 8'h10;
    localparam logic [7:0] A_WDT = 8'h14;
    localparam logic [7:0] A_EXTI = 8'h18;
    localparam logic [7:0] A_XMEM = 8'h1c;
    localparam logic [7:0] A_OSC = 8'h20;
    // Feature enable fields
    localparam int F_USART1 = 0;
    localparam int F_SYNC = 1;
    localparam int F_TMR3 = 2;
    localparam int F_OCRC = 3;
    localparam int F_TWI = 4;
    localparam int F_BOOT = 5;
    localparam int F_FIFO = 6;
    localparam int FEAT_W = 7;
    localparam logic [6:0] FEAT_RST = 7'h00;
    // Reset cause flags
    localparam int RSTF_W = 5;
    localparam logic [4:0] RSTF_LEGACY = 5'h03;
    localparam logic [4:0] RSTF_RST = 5'h00;
    // Baud divisor
    localparam int BAUD_W = 12;
    localparam int BAUD_LEGACY_W = 8;
    localparam logic [11:0] BAUD_RST = 12'h000;
    // Watchdog fields and unlock window
    localparam int WD_EN = 3;
    localparam int WD_CHG = 4;
    localparam logic [2:0] WD_TO_RST = 3'h0;
    localparam logic [2:0] WDT_UNLOCK_CYC = 3'h4;
    // External interrupt sense, two bits per input
    localparam logic [15:0] EXTI_LEGACY_KEEP = 16'hff00;
    localparam logic [15:0] EXTI_RST = 16'h0000;
    // External memory fields
    localparam int XM_SPLIT = 3;
    localparam int XM_WLO = 4;
    localparam int XM_WHI = 6;
    localparam logic [7:0] XMEM_RST = 8'h00;
    localparam logic [7:0] OSC_RST = 8'h80;
    // Data space map
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] IO_HI = 16'h005f;
    localparam logic [15:0] EXT_LO = 16'h0060;
    localparam logic [15:0] EXT_HI = 16'h00ff;
    localparam logic [5:0] VEC_LEGACY_CNT = 6'h10;
    // Fuse settle cycles after reset release
    localparam logic [1:0] FUSE_SETTLE = 2'h2;
endpackage

// File: src/legacy_fuse_sampler.sv
`timescale 1ns/1ps
module legacy_fuse_sampler
    import legacy_compat_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fuse_pin,
    output logic mode,
    output logic mode_valid
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [1:0] cnt;
        logic mode;
        logic valid;
    } smp_s;

    smp_s st_ff;
    smp_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = fuse_pin;
        nxt_st.s2 = st_ff.s1;
        if (!st_ff.valid) begin
            if (st_ff.cnt == FUSE_SETTLE) begin
                nxt_st.mode = st_ff.s2;
                nxt_st.valid = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mode = st_ff.mode;
    assign mode_valid = st_ff.valid;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_fuse_capture: assert property ($rose(st_ff.valid) |-> st_ff.mode == $past(st_ff.s2))
        else $error("mode not taken from fuse");
    chk_mode_frozen: assert property (st_ff.valid |=> $stable(st_ff.mode) && st_ff.valid)
        else $error("mode changed after capture");
endmodule

// File: src/port_mode_gate.sv
`timescale 1ns/1ps
module port_mode_gate (
    input wire logic compat,
    input wire logic [7:0] c_ddr,
    input wire logic [7:0] f_ddr,
    input wire logic [4:0] g_ddr,
    input wire logic [4:0] g_alt_sel,
    input wire logic [4:0] g_alt_oe,
    output logic [7:0] c_oe,
    output logic [7:0] f_oe,
    output logic [4:0] g_oe
);
    for (genvar i = 0; i < 8; i++) begin : g_cf
        assign c_oe[i] = compat | c_ddr[i];
        assign f_oe[i] = ~compat & f_ddr[i];
    end
    for (genvar j = 0; j < 5; j++) begin : g_g
        // In legacy mode the pin follows its alternate function only
        assign g_oe[j] = (compat | g_alt_sel[j]) ? g_alt_oe[j] : g_ddr[j];
    end
endmodule

// File: tb/legacy_compat_ctrl_tb.sv
`timescale 1ns/1ps
module legacy_compat_ctrl_tb;
    import legacy_compat_pkg::*;
    typedef struct packed {logic [31:0] d; logic e;} note_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, legacy_mode_fuse, io_instr;
    logic [7:0] paddr, c_ddr, f_ddr, c_oe, f_oe, osccal;
    logic [31:0] pwdata, prdata;
    logic [15:0] data_addr, io_data_addr, int_sense;
    logic [5:0] io_addr, vec_index;
    logic io_sel, ext_io_sel, ram_sel, vec_enable, rst_por, rst_ext, rst_bod, rst_wdt, rst_jtag;
    logic [4:0] g_ddr, g_alt_sel, g_alt_oe, g_oe, mcu_control_status_reg;
    logic compat_mode, mode_ready, usart1_en, usart_sync_en, timer3_en, ocr_c_en;
    logic twi_en, boot_en, rx_fifo_en, wdt_en, xmem_split;
    logic [11:0] baud_div;
    logic [2:0] wdt_timeout, xmem_release;
    logic [1:0] xmem_wait_lo, xmem_wait_hi;
    logic [6:0] feat;
    note_s notes[$];
    note_s cur;
    int fail_count = 0;
    int num_checks = 0;
    integer seed = 32'h4b54;

    legacy_compat_ctrl DUT (.*);

    assign feat = {rx_fifo_en, boot_en, twi_en, ocr_c_en, timer3_en, usart_sync_en, usart1_en};

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, io_instr, legacy_mode_fuse} = 5'h00;
        {rst_por, rst_ext, rst_bod, rst_wdt, rst_jtag} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        data_addr = 16'h0000;
        {io_addr, vec_index} = 12'h000;
        {c_ddr, f_ddr} = 16'h0000;
        {g_ddr, g_alt_sel, g_alt_oe} = 15'h0000;
    end

    always #10 pclk = ~pclk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One APB transfer; a read notes its expected word and error flag
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        @(posedge pclk);
        if (!wr) notes.push_back('{exp, err});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            cur = notes.pop_front();
            check("prdata", prdata, cur.d);
            check("pslverr", {31'h0, pslverr}, {31'h0, cur.e});
        end
    end

    task automatic do_reset(input logic f);
        legacy_mode_fuse <= f;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk) check("mode_ready early", {31'h0, mode_ready}, 32'h0);
        @(negedge pclk) check("mode_ready", {31'h0, mode_ready}, 32'h1);
    endtask

    task automatic pulse_flags();
        @(posedge pclk);
        {rst_por, rst_ext, rst_bod, rst_wdt, rst_jtag} <= 5'h1f;
        @(posedge pclk);
        {rst_por, rst_ext, rst_bod, rst_wdt, rst_jtag} <= 5'h00;
    endtask

    task automatic decode(input logic [15:0] da, input logic [5:0] vi);
        @(posedge pclk);
        data_addr <= da;
        vec_index <= vi;
        c_ddr <= 8'($random(seed));
        f_ddr <= 8'($random(seed));
        {g_ddr, g_alt_sel, g_alt_oe} <= 15'($random(seed));
        @(negedge pclk);
    endtask

    initial begin
        do_reset(1'b0);
        apb(1'b0, A_MODE, 0, 32'h0000_0002, 1'b0);
        apb(1'b1, A_FEAT, 32'h0000_007f, 0, 1'b0);
        apb(1'b0, A_STAT, 0, 32'h0000_007f, 1'b0);
        apb(1'b1, A_BAUD, 32'h0000_0fff, 0, 1'b0);
        apb(1'b0, A_BAUD, 0, 32'h0000_0fff, 1'b0);
        apb(1'b0, 8'h24, 0, 32'h0000_0000, 1'b1);
        apb(1'b1, A_WDT, 32'h0000_0007, 0, 1'b0);
        @(negedge pclk) check("wdt locked", {29'h0, wdt_timeout}, 32'h0);
        apb(1'b1, A_WDT, 32'h0000_0018, 0, 1'b0);
        apb(1'b1, A_WDT, 32'h0000_000d, 0, 1'b0);
        @(negedge pclk) check("wdt unlocked", {28'h0, wdt_en, wdt_timeout}, 32'hd);
        pulse_flags();
        apb(1'b0, A_RSTF, 0, 32'h0000_001f, 1'b0);
        // Clear the flags while two reset events land on the same edge
        fork
            apb(1'b1, A_RSTF, 32'h0000_0000, 0, 1'b0);
            begin
                repeat (2) @(posedge pclk);
                {rst_por, rst_ext} <= 2'h3;
                @(posedge pclk);
                {rst_por, rst_ext} <= 2'h0;
            end
        join
        apb(1'b0, A_RSTF, 0, 32'h0000_0003, 1'b0);
        decode(16'h0060, 6'h14);
        check("ext lo", {31'h0, ext_io_sel}, 32'h1);
        check("vec normal", {31'h0, vec_enable}, 32'h1);
        check("c_oe", {24'h0, c_oe}, {24'h0, c_ddr});
        check("g_oe", {27'h0, g_oe}, {27'h0, (g_alt_sel & g_alt_oe) | (~g_alt_sel & g_ddr)});
        decode(16'h00ff, 6'h00);
        check("ext hi", {30'h0, ext_io_sel, ram_sel}, 32'h2);
        check("f_oe", {24'h0, f_oe}, {24'h0, f_ddr});
        decode(16'h0100, 6'h00);
        check("ram above", {30'h0, ext_io_sel, ram_sel}, 32'h1);
        @(posedge pclk);
        io_instr <= 1'b1;
        io_addr <= 6'h3f;
        data_addr <= 16'h0080;
        @(negedge pclk) check("io addr", {16'h0, io_data_addr}, 32'h005f);
        check("short io", {31'h0, ext_io_sel}, 32'h0);
        check("io sel", {31'h0, io_sel}, 32'h1);
        @(posedge pclk);
        io_instr <= 1'b0;
        $display("test normal mode done");

        do_reset(1'b1);
        apb(1'b0, A_MODE, 0, 32'h0000_0003, 1'b0);
        @(posedge pclk);
        legacy_mode_fuse <= 1'b0;
        repeat (10) @(posedge pclk);
        @(negedge pclk) check("mode held", {31'h0, compat_mode}, 32'h1);
        apb(1'b1, A_FEAT, 32'h0000_007f, 0, 1'b0);
        apb(1'b0, A_STAT, 0, 32'h0000_0000, 1'b0);
        @(negedge pclk) check("features", {25'h0, feat}, 32'h0);
        apb(1'b1, A_BAUD, 32'h0000_0fff, 0, 1'b0);
        apb(1'b0, A_BAUD, 0, 32'h0000_00ff, 1'b0);
        apb(1'b1, A_OSC, 32'h0000_0012, 0, 1'b0);
        apb(1'b0, A_OSC, 0, 32'h0000_0080, 1'b0);
        apb(1'b1, A_XMEM, 32'h0000_005f, 0, 1'b0);
        apb(1'b0, A_XMEM, 0, 32'h0000_0050, 1'b0);
        @(negedge pclk) check("xmem", {24'h0, xmem_release, xmem_split, xmem_wait_hi, xmem_wait_lo}, 32'h5);
        apb(1'b1, A_EXTI, 32'h0000_ffff, 0, 1'b0);
        apb(1'b0, A_EXTI, 0, 32'h0000_ff00, 1'b0);
        apb(1'b1, A_WDT, 32'h0000_0005, 0, 1'b0);
        @(negedge pclk) check("wdt direct", {29'h0, wdt_timeout}, 32'h5);
        check("baud_div", {20'h0, baud_div}, 32'h0000_00ff);
        check("osccal", {24'h0, osccal}, 32'h0000_0080);
        check("int_sense", {16'h0, int_sense}, 32'h0000_ff00);
        pulse_flags();
        apb(1'b0, A_RSTF, 0, 32'h0000_0003, 1'b0);
        @(negedge pclk) check("flags", {27'h0, mcu_control_status_reg}, 32'h3);
        decode(16'h0080, 6'h10);
        check("ram legacy", {30'h0, ext_io_sel, ram_sel}, 32'h1);
        check("vec 16", {31'h0, vec_enable}, 32'h0);
        check("c_oe legacy", {24'h0, c_oe}, 32'h0000_00ff);
        check("f_oe legacy", {24'h0, f_oe}, 32'h0);
        check("g_oe legacy", {27'h0, g_oe}, {27'h0, g_alt_oe});
        decode(16'h0060, 6'h0f);
        check("vec 15", {31'h0, vec_enable}, 32'h1);
        check("ext legacy", {31'h0, ext_io_sel}, 32'h0);
        $display("test legacy mode done");
        close_out();
    end

    initial begin
        #200000;
        fail_count++;
        close_out();
    end
endmodule
